// ===== hw/clock_sync_serial_channel.sv
// clock synchronous serial channel: shift clock, transmit and receive
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
module clock_sync_serial_channel (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	input  wire logic [7:0]            mode_reg,
	input  wire logic [7:0]            ctrl0_reg,
	input  wire sync_serial_pkg::byte_t baud_reg,
	input  wire logic                  tx_enable,
	input  wire logic                  rx_enable,
	input  wire logic                  tx_write,
	input  wire sync_serial_pkg::byte_t tx_data,
	input  wire logic                  rx_read,
	input  wire logic                  shift_clock_pin_in,
	output logic                       shift_clock_pin_out,
	output logic                       shift_clock_pin_oe,
	output logic                       serial_out_pin,
	input  wire logic                  serial_in_pin,
	input  wire logic                  clear_to_send_input,
	output logic                       ready_to_receive_output,
	output logic                       tx_buf_empty,
	output logic                       tx_reg_empty,
	output logic                       rx_complete,
	output logic                       overrun_err,
	output sync_serial_pkg::byte_t     rx_data,
	output logic                       tx_irq_pulse,
	output logic                       rx_irq_pulse
);
	import sync_serial_pkg::*;

	rate_div_if div_bus ();

	shift_state_t state_ff;
	shift_state_t nxt_state;
	byte_t        tx_buf_ff;
	byte_t        nxt_tx_buf;
	byte_t        tx_sh_ff;
	byte_t        nxt_tx_sh;
	byte_t        rx_sh_ff;
	byte_t        nxt_rx_sh;
	byte_t        rx_buf_ff;
	byte_t        nxt_rx_buf;
	logic [2:0]   bit_cnt_ff;
	logic [2:0]   nxt_bit_cnt;
	logic         sclk_ff;
	logic         nxt_sclk;
	logic         oe_ff;
	logic         nxt_oe;
	logic         ext_prev_ff;
	logic         nxt_ext_prev;
	logic         ser_out_ff;
	logic         nxt_ser_out;
	logic         rts_ff;
	logic         nxt_rts;
	logic         tx_buf_empty_ff;
	logic         nxt_tx_buf_empty;
	logic         tx_reg_empty_ff;
	logic         nxt_tx_reg_empty;
	logic         rx_complete_ff;
	logic         nxt_rx_complete;
	logic         overrun_ff;
	logic         nxt_overrun;
	logic         rx_active_ff;
	logic         nxt_rx_active;
	logic         tx_irq_ff;
	logic         nxt_tx_irq;
	logic         rx_irq_ff;
	logic         nxt_rx_irq;

	logic sync_mode;
	logic ext_clk;
	logic hs_off;
	logic start_ok;
	logic fall_ev;
	logic rise_ev;
	logic last_bit;

	assign sync_mode = (mode_reg[`MODE_SEL_MSB:`MODE_SEL_LSB] == `MODE_SYNC);
	assign ext_clk   = mode_reg[`MODE_CLK_EXT_BIT];
	assign hs_off    = ctrl0_reg[`CTRL0_HS_BIT];
	// receive rides on the same start: no separate receive trigger exists
	assign start_ok  = sync_mode & tx_enable & ~tx_buf_empty_ff
		& (hs_off | ~clear_to_send_input);

	// pin input treated as synchronous; edges only count inside a frame
	assign fall_ev  = (state_ff == st_shift)
		& (ext_clk ? (ext_prev_ff & ~shift_clock_pin_in) : (div_bus.underflow & sclk_ff));
	assign rise_ev  = (state_ff == st_shift)
		& (ext_clk ? (~ext_prev_ff & shift_clock_pin_in) : (div_bus.underflow & ~sclk_ff));
	assign last_bit = rise_ev & (bit_cnt_ff == `FRAME_LAST);

	assign div_bus.run     = (state_ff == st_shift) & ~ext_clk;
	assign div_bus.src_sel = src_sel_t'(ctrl0_reg[`CTRL0_SRC_MSB:`CTRL0_SRC_LSB]);
	assign div_bus.divisor = baud_reg;

	rate_divider u_rate_divider (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.div_bus (div_bus.div)
	);

	always_comb begin
		nxt_state        = state_ff;
		nxt_tx_buf       = tx_buf_ff;
		nxt_tx_sh        = tx_sh_ff;
		nxt_rx_sh        = rx_sh_ff;
		nxt_rx_buf       = rx_buf_ff;
		nxt_bit_cnt      = bit_cnt_ff;
		nxt_sclk         = sclk_ff;
		nxt_ser_out      = ser_out_ff;
		nxt_tx_buf_empty = tx_buf_empty_ff;
		nxt_tx_reg_empty = tx_reg_empty_ff;
		nxt_rx_complete  = rx_complete_ff;
		nxt_overrun      = overrun_ff;
		nxt_rx_active    = rx_active_ff;
		nxt_tx_irq       = 1'b0;
		nxt_rx_irq       = 1'b0;
		nxt_ext_prev     = shift_clock_pin_in;
		nxt_oe           = sync_mode & ~ext_clk;

		// clears first so a completion in the same cycle wins
		if (rx_read || !rx_enable) begin
			nxt_rx_complete = 1'b0;
			nxt_overrun     = 1'b0;
		end

		if (fall_ev) begin
			if (!ext_clk) begin
				nxt_sclk = 1'b0;
			end
			nxt_ser_out = tx_sh_ff[0];
			nxt_tx_sh   = {1'b0, tx_sh_ff[7:1]};
		end

		if (rise_ev) begin
			if (!ext_clk) begin
				nxt_sclk = 1'b1;
			end
			nxt_bit_cnt = bit_cnt_ff + 3'h1;
			if (rx_active_ff) begin
				nxt_rx_sh = {serial_in_pin, rx_sh_ff[7:1]};
			end
		end

		if (last_bit) begin
			nxt_state        = st_idle;
			nxt_tx_reg_empty = 1'b1;
			nxt_rx_active    = 1'b0;
			if (rx_active_ff) begin
				nxt_rx_buf = {serial_in_pin, rx_sh_ff[7:1]};
				if (nxt_rx_complete) begin
					nxt_overrun = 1'b1;
				end else begin
					nxt_rx_complete = 1'b1;
					nxt_rx_irq      = 1'b1;
				end
			end
		end

		unique case (state_ff)
			st_idle: begin
				nxt_sclk = `SCLK_IDLE;
			end
			st_shift: begin
				if (!sync_mode) begin
					nxt_state     = st_idle;
					nxt_rx_active = 1'b0;
				end
			end
		endcase

		// a start at the last rising edge keeps the clock running gaplessly
		if (start_ok && (state_ff == st_idle || last_bit)) begin
			nxt_state        = st_shift;
			nxt_tx_sh        = tx_buf_ff;
			nxt_bit_cnt      = `BIT_CNT_RST;
			nxt_tx_buf_empty = 1'b1;
			nxt_tx_reg_empty = 1'b0;
			nxt_tx_irq       = 1'b1;
			nxt_rx_active    = rx_enable;
			nxt_sclk         = `SCLK_IDLE;
		end

		if (tx_write) begin
			nxt_tx_buf       = tx_data;
			nxt_tx_buf_empty = 1'b0;
		end

		nxt_rts = ~(~hs_off & 1'b0) & ~(hs_off & rx_enable & ~nxt_rx_active);
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff        <= st_idle;
			tx_buf_ff       <= `BYTE_RST;
			tx_sh_ff        <= `BYTE_RST;
			rx_sh_ff        <= `BYTE_RST;
			rx_buf_ff       <= `BYTE_RST;
			bit_cnt_ff      <= `BIT_CNT_RST;
			sclk_ff         <= `SCLK_IDLE;
			oe_ff           <= 1'b0;
			ext_prev_ff     <= `SCLK_IDLE;
			ser_out_ff      <= `SER_OUT_IDLE;
			rts_ff          <= `RTS_IDLE;
			tx_buf_empty_ff <= `TX_BUF_EMPTY_RST;
			tx_reg_empty_ff <= `TX_REG_EMPTY_RST;
			rx_complete_ff  <= 1'b0;
			overrun_ff      <= 1'b0;
			rx_active_ff    <= 1'b0;
			tx_irq_ff       <= 1'b0;
			rx_irq_ff       <= 1'b0;
		end else begin
			state_ff        <= nxt_state;
			tx_buf_ff       <= nxt_tx_buf;
			tx_sh_ff        <= nxt_tx_sh;
			rx_sh_ff        <= nxt_rx_sh;
			rx_buf_ff       <= nxt_rx_buf;
			bit_cnt_ff      <= nxt_bit_cnt;
			sclk_ff         <= nxt_sclk;
			oe_ff           <= nxt_oe;
			ext_prev_ff     <= nxt_ext_prev;
			ser_out_ff      <= nxt_ser_out;
			rts_ff          <= nxt_rts;
			tx_buf_empty_ff <= nxt_tx_buf_empty;
			tx_reg_empty_ff <= nxt_tx_reg_empty;
			rx_complete_ff  <= nxt_rx_complete;
			overrun_ff      <= nxt_overrun;
			rx_active_ff    <= nxt_rx_active;
			tx_irq_ff       <= nxt_tx_irq;
			rx_irq_ff       <= nxt_rx_irq;
		end
	end

	assign shift_clock_pin_out     = sclk_ff;
	assign shift_clock_pin_oe      = oe_ff;
	assign serial_out_pin          = ser_out_ff;
	assign ready_to_receive_output = rts_ff;
	assign tx_buf_empty            = tx_buf_empty_ff;
	assign tx_reg_empty            = tx_reg_empty_ff;
	assign rx_complete             = rx_complete_ff;
	assign overrun_err             = overrun_ff;
	assign rx_data                 = rx_buf_ff;
	assign tx_irq_pulse            = tx_irq_ff;
	assign rx_irq_pulse            = rx_irq_ff;
endmodule

// ===== hw/rate_div_if.sv
// link between the channel and its rate divider
`timescale 1ns/1ps
interface rate_div_if;
	import sync_serial_pkg::*;
	logic     run;
	src_sel_t src_sel;
	byte_t    divisor;
	logic     underflow;

	modport ctl (output run, output src_sel, output divisor, input underflow);
	modport div (input run, input src_sel, input divisor, output underflow);
endinterface

// ===== hw/rate_divider.sv
// prescaler plus 8-bit reload divider producing underflow pulses
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
module rate_divider (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	rate_div_if.div   div_bus
);
	import sync_serial_pkg::*;

	logic [8:0] pre_ff;
	logic [8:0] nxt_pre;
	byte_t      cnt_ff;
	byte_t      nxt_cnt;
	logic       uf_ff;
	logic       nxt_uf;
	logic [8:0] pre_term;
	logic       tick;

	always_comb begin
		unique case (div_bus.src_sel)
			src_f2:   pre_term = `PRE_TERM_F2;
			src_f16:  pre_term = `PRE_TERM_F16;
			src_f64:  pre_term = `PRE_TERM_F64;
			src_f512: pre_term = `PRE_TERM_F512;
		endcase
	end

	assign tick = (pre_ff == pre_term);

	always_comb begin
		nxt_pre = pre_ff;
		nxt_cnt = cnt_ff;
		nxt_uf  = 1'b0;
		if (!div_bus.run) begin
			// held at reload while idle so each frame starts a full period
			nxt_pre = 9'h000;
			nxt_cnt = div_bus.divisor;
		end else begin
			nxt_pre = tick ? 9'h000 : pre_ff + 9'h001;
			if (tick) begin
				if (cnt_ff == 8'h00) begin
					nxt_uf  = 1'b1;
					nxt_cnt = div_bus.divisor;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_ff <= 9'h000;
			cnt_ff <= `BYTE_RST;
			uf_ff  <= 1'b0;
		end else begin
			pre_ff <= nxt_pre;
			cnt_ff <= nxt_cnt;
			uf_ff  <= nxt_uf;
		end
	end

	assign div_bus.underflow = uf_ff;
endmodule

// ===== hw/sync_serial_cfg.svh
// constants for the clock synchronous serial channel
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH

`define MODE_SEL_LSB      0
`define MODE_SEL_MSB      2
`define MODE_SYNC         3'h1
`define MODE_CLK_EXT_BIT  3
`define MODE_SLEEP_BIT    7

`define CTRL0_SRC_LSB     0
`define CTRL0_SRC_MSB     1
`define CTRL0_HS_BIT      2

`define FRAME_LAST        3'h7
`define BIT_CNT_RST       3'h0

`define PRE_TERM_F2       9'h001
`define PRE_TERM_F16      9'h00f
`define PRE_TERM_F64      9'h03f
`define PRE_TERM_F512     9'h1ff

`define SCLK_IDLE         1'b1
`define TX_BUF_EMPTY_RST  1'b1
`define TX_REG_EMPTY_RST  1'b1
`define SER_OUT_IDLE      1'b1
`define RTS_IDLE          1'b1
`define BYTE_RST          8'h00

`endif

// ===== hw/sync_serial_pkg.sv
// types shared by the clock synchronous serial channel
package sync_serial_pkg;
	typedef enum logic [0:0] {
		st_idle  = 1'b0,
		st_shift = 1'b1
	} shift_state_t;

	typedef enum logic [1:0] {
		src_f2   = 2'b00,
		src_f16  = 2'b01,
		src_f64  = 2'b10,
		src_f512 = 2'b11
	} src_sel_t;

	typedef logic [7:0] byte_t;
endpackage

// ===== sim/clock_sync_serial_channel_checker.sv
// port-level assertions for the clock synchronous serial channel
`timescale 1ns/1ps
module clock_sync_serial_channel_checker (
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic [7:0] mode_reg,
	input wire logic [7:0] ctrl0_reg,
	input wire logic       tx_enable,
	input wire logic       rx_enable,
	input wire logic       tx_write,
	input wire logic       rx_read,
	input wire logic       shift_clock_pin_out,
	input wire logic       shift_clock_pin_oe,
	input wire logic       serial_out_pin,
	input wire logic       ready_to_receive_output,
	input wire logic       tx_buf_empty,
	input wire logic       tx_reg_empty,
	input wire logic       rx_complete,
	input wire logic       overrun_err,
	input wire logic       tx_irq_pulse,
	input wire logic       rx_irq_pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_oe; 1'b1 |=> shift_clock_pin_oe == ($past(mode_reg[3:0]) == 4'h1); endproperty
	a_oe: assert property (p_oe) else $error("clock pin direction wrong");
	property p_buf; tx_write |=> !tx_buf_empty; endproperty
	a_buf: assert property (p_buf) else $error("buffer write left empty flag set");
	property p_start; $rose(tx_irq_pulse) |-> !tx_reg_empty && $past(tx_enable); endproperty
	a_start: assert property (p_start) else $error("transmit start flags wrong");
	property p_irq1; tx_irq_pulse |=> !tx_irq_pulse; endproperty
	a_irq1: assert property (p_irq1) else $error("transmit request longer than one cycle");
	property p_rest; tx_buf_empty && tx_reg_empty && shift_clock_pin_oe |-> shift_clock_pin_out; endproperty
	a_rest: assert property (p_rest) else $error("idle shift clock not high");
	property p_txd; $changed(serial_out_pin) && shift_clock_pin_oe |-> $fell(shift_clock_pin_out); endproperty
	a_txd: assert property (p_txd) else $error("serial out moved off a falling edge");
	property p_rxi; rx_irq_pulse |-> rx_complete && !overrun_err; endproperty
	a_rxi: assert property (p_rxi) else $error("receive request with wrong flags");
	property p_rd; rx_read |=> !overrun_err && (rx_irq_pulse || !rx_complete); endproperty
	a_rd: assert property (p_rd) else $error("buffer read did not clear flags");
	property p_rxoff; !rx_enable |=> !rx_complete && !overrun_err; endproperty
	a_rxoff: assert property (p_rxoff) else $error("flags set with receiver off");
	property p_rts; !ctrl0_reg[2] |=> ready_to_receive_output; endproperty
	a_rts: assert property (p_rts) else $error("ready output driven while not selected");
endmodule
bind clock_sync_serial_channel clock_sync_serial_channel_checker u_chk (.sys_clk, .rst_b, .mode_reg, .ctrl0_reg,
	.tx_enable, .rx_enable, .tx_write, .rx_read, .shift_clock_pin_out, .shift_clock_pin_oe, .serial_out_pin,
	.ready_to_receive_output, .tx_buf_empty, .tx_reg_empty, .rx_complete, .overrun_err, .tx_irq_pulse, .rx_irq_pulse);

// ===== sim/serial_peer.sv
// behavioural peer device on the far side of the serial link
`timescale 1ns/1ps
module serial_peer (
	input  wire logic       sys_clk,
	input  wire logic       sclk,
	input  wire logic       ext_go,
	input  wire logic [7:0] tx_byte,
	input  wire logic       serial_out_pin,
	output logic            serial_in_pin,
	output logic            peer_clk,
	output logic [7:0]      rx_byte
);
	logic       sclk_d;
	logic [2:0] bit_n;
	logic [1:0] hold;
	logic [1:0] ph;
	logic [4:0] ext_n;
	initial begin
		{sclk_d, peer_clk, serial_in_pin} = 3'h7;
		{bit_n, hold, ph, ext_n, rx_byte} = '0;
	end
	always @(posedge sys_clk) begin
		sclk_d <= sclk;
		if (sclk_d && !sclk) begin
			serial_in_pin <= tx_byte[bit_n]; // lsb first
		end else if (!sclk_d && sclk) begin
			rx_byte <= {serial_out_pin, rx_byte[7:1]};
			bit_n <= bit_n + 3'h1;
			hold <= 2'h3;
		end else if (hold != 0) begin
			hold <= hold - 2'h1;
		end else if (sclk) begin
			serial_in_pin <= !serial_in_pin; // hold time over: no stale level
		end
		if (ext_go) begin
			ext_n <= 5'h10;
		end else if (ext_n != 0) begin
			ph <= ph + 2'h1;
			if (ph == 2'h3) begin
				peer_clk <= !peer_clk; // clock runs only inside a frame
				ext_n <= ext_n - 5'h1;
			end
		end
	end
endmodule

// ===== sim/tb_clock_sync_serial_channel.sv
// self-checking bench for the clock synchronous serial channel
`timescale 1ns/1ps
module tb_clock_sync_serial_channel;
	import sync_serial_pkg::*;
	logic sys_clk = 0, rst_b = 0, tx_enable = 0, rx_enable = 0, tx_write = 0, rx_read = 0, cts_n = 1, ext_go = 0;
	logic [7:0] mode_reg = 8'h01, ctrl0_reg = 8'h04, peer_tx = 8'h00, peer_rx, d;
	byte_t baud_reg = 8'h00, tx_data = 8'h00, rxd;
	logic sco, soe, sout, sin, rts, tbe, tre, rxc, ovr, txi, rxi, peer_clk, sclk_q;
	int n_fail = 0, check_count = 0, seed = 50, nfall, ntx, nrx, lowrun, last_low, hr, maxh, i, k, n, src;
	wire sclk = soe ? sco : peer_clk;
	always #5 sys_clk = !sys_clk;
	clock_sync_serial_channel DUT (.sys_clk(sys_clk), .rst_b(rst_b), .mode_reg(mode_reg), .ctrl0_reg(ctrl0_reg),
		.baud_reg(baud_reg), .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_write(tx_write), .tx_data(tx_data),
		.rx_read(rx_read), .shift_clock_pin_in(sclk), .shift_clock_pin_out(sco), .shift_clock_pin_oe(soe),
		.serial_out_pin(sout), .serial_in_pin(sin), .clear_to_send_input(cts_n), .ready_to_receive_output(rts),
		.tx_buf_empty(tbe), .tx_reg_empty(tre), .rx_complete(rxc), .overrun_err(ovr), .rx_data(rxd),
		.tx_irq_pulse(txi), .rx_irq_pulse(rxi));
	serial_peer peer (.sys_clk(sys_clk), .sclk(sclk), .ext_go(ext_go), .tx_byte(peer_tx),
		.serial_out_pin(sout), .serial_in_pin(sin), .peer_clk(peer_clk), .rx_byte(peer_rx));
	always @(posedge sys_clk) begin
		sclk_q <= sclk;
		if (sclk_q && !sclk) nfall++;
		if (txi === 1'b1) ntx++;
		if (rxi === 1'b1) nrx++;
		if (!sclk) lowrun++;
		else if (lowrun != 0) begin
			last_low = lowrun;
			lowrun = 0;
		end
		if (sclk && nfall > 0 && !(tbe && tre)) hr++;
		else begin
			if (hr > maxh) maxh = hr;
			hr = 0;
		end
	end
	function automatic int half_of(input int s, input int nv);
		return (nv + 1) * (s ? 16 : 2); // prescale then divide by n plus one
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] v);
		{nfall, ntx, nrx, maxh} = '0;
		tx_data <= v;
		tx_write <= 1;
		@(posedge sys_clk);
		tx_write <= 0;
	endtask
	task automatic pulse_read();
		rx_read <= 1;
		@(posedge sys_clk);
		rx_read <= 0;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic wait_idle();
		repeat (3) @(posedge sys_clk);
		for (k = 0; k < 5000 && !(tbe === 1'b1 && tre === 1'b1); k++) @(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#600us; // roughly ten times the longest expected run
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1;
		@(posedge sys_clk);
		chk("reset flags", 16'h000f, {tbe, tre, sco, sout});
		tx_enable <= 1;
		rx_enable <= 1;
		for (i = 0; i < 8; i++) begin
			src = $random(seed) & 1;
			n = $random(seed) & 3;
			d = $random(seed);
			if (i == 0) {src, n, d} = {32'd0, 32'd0, 8'h01}; // fastest rate, single bit set
			if (i == 1) {src, n, d} = {32'd1, 32'd3, 8'h80};
			peer_tx <= $random(seed);
			baud_reg <= n[7:0];
			ctrl0_reg <= 8'h04 | src[7:0];
			@(posedge sys_clk);
			send(d); // data doubles as dummy write for receive
			wait_idle();
			chk("falls", 16'd8, nfall[15:0]);
			chk("half period", 16'(half_of(src, n)), last_low[15:0]);
			chk("peer byte", d, peer_rx);
			chk("rx data", peer_tx, rxd);
			chk("irqs", 16'h0101, {ntx[7:0], nrx[7:0]});
			chk("flags", 16'h0002, {rxc, ovr});
			pulse_read();
			chk("read clears", 16'h0, {rxc, ovr});
		end
		baud_reg <= 8'h03;
		ctrl0_reg <= 8'h00;
		tx_enable <= 0;
		cts_n <= 0;
		send(8'h5a);
		repeat (40) @(posedge sys_clk);
		chk("no start disabled", 16'h0, {nfall[7:0], tbe});
		tx_enable <= 1;
		cts_n <= 1;
		repeat (40) @(posedge sys_clk);
		chk("no start cts high", 16'h0, {nfall[7:0], tbe});
		cts_n <= 0;
		wait_idle();
		chk("cts byte", 16'h5a, peer_rx);
		pulse_read();
		ctrl0_reg <= 8'h04;
		send(8'hc3);
		for (k = 0; k < 100 && tbe !== 1'b1; k++) @(posedge sys_clk);
		send(8'h3c);
		wait_idle();
		chk("b2b falls", 16'd16, nfall[15:0]);
		chk("no gap", 16'd8, maxh[15:0]);
		chk("b2b byte", 16'h3c, peer_rx);
		chk("overrun", {8'hc1, peer_tx}, {rxc, ovr, nrx[5:0], rxd});
		pulse_read();
		mode_reg <= 8'h00;
		send(8'h96);
		repeat (30) @(posedge sys_clk);
		chk("mode off", 16'h0, {nfall[7:0], soe, tbe});
		mode_reg <= 8'h09; // sleep bit kept low
		repeat (20) @(posedge sys_clk);
		chk("ext wait", 16'h1, {nfall[7:0], soe, rts});
		ext_go <= 1;
		@(posedge sys_clk);
		ext_go <= 0;
		repeat (12) @(posedge sys_clk);
		chk("rts busy", 16'h1, rts);
		wait_idle();
		chk("ext byte", {8'h96, peer_tx}, {peer_rx, rxd});
		rx_enable <= 0;
		mode_reg <= 8'h01;
		send(8'h0f);
		wait_idle();
		chk("rx off", 16'h0f00, {peer_rx, rxc, nrx[6:0]});
		stop_test();
	end
endmodule
